/* common/sfe_consts.svh */
/*
   Constants for the serial flash erase and identification command block:
   opcodes, bit counts, block masks, erase kinds, times and reset values.
   Assumes it is included by bare name from every design file that needs it.
*/
`ifndef SFE_CONSTS_SVH
`define SFE_CONSTS_SVH
// opcodes
`define SFE_OP_HALF_BE  8'h52
`define SFE_OP_FULL_BE  8'hD8
`define SFE_OP_CHIP_A   8'h60
`define SFE_OP_CHIP_B   8'hC7
`define SFE_OP_PUMP     8'hA3
`define SFE_OP_RELEASE  8'hAB
`define SFE_OP_DEEP_PD  8'hB9
`define SFE_OP_MAKER_ID 8'h90
`define SFE_OP_IDENT    8'h9F
`define SFE_OP_UNIQUE   8'h4B
// bit counts at which a frame or a field ends, and the value at which the count saturates
`define SFE_BITS_OP     8'h08
`define SFE_BITS_ADDR   8'h20
`define SFE_BITS_UNIQUE 8'h28
`define SFE_BITS_MAX    8'hFF
// block base masks
`define SFE_HALF_MASK   24'hFF_8000
`define SFE_FULL_MASK   24'hFF_0000
// erase kinds
`define SFE_KIND_HALF   2'h0
`define SFE_KIND_FULL   2'h1
`define SFE_KIND_CHIP   2'h2
// clock rate and erase times in microseconds
`define SFE_CLK_MHZ     40
`define SFE_HALF_BE_US  1000
`define SFE_FULL_BE_US  2000
`define SFE_CHIP_US     8000
// reset values
`define SFE_CS_IDLE     1'b1
`define SFE_SYNC_RST    3'h5
`endif

/* common/sfe_pkg.sv */
/*
   Types for the serial flash erase and identification command block.
   Assumes nothing beyond a SystemVerilog compiler.
*/
package sfe_pkg;
   // frame phase of the serial link
   typedef enum logic [1:0] {SFE_IDLE, SFE_RECV, SFE_SEND, SFE_SKIP} sfe_phase_t;

   // state of the command decoder
   typedef struct packed {
      sfe_phase_t   phase;
      logic         cs_q;
      logic         sclk_q;
      logic [7:0]   bits;
      logic [7:0]   opcode;
      logic [23:0]  addr;
      logic [127:0] out_sr;
      logic         so;
      logic         so_oe;
      logic         fast_pump;
      logic         erase_go;
      logic [1:0]   erase_kind;
      logic [23:0]  erase_base;
      logic         unlock_clear;
      logic         probe_full;
   } sfe_state_t;

   // state of the erase cycle timer
   typedef struct packed {
      logic        busy;
      logic [31:0] count;
   } sfe_timer_t;
endpackage : sfe_pkg

/* logic/sfe_sync.sv */
/*
   Two flip-flop synchroniser for the link pins.
   Assumes reset is already released in step with clock.
*/
`timescale 1ns/1ps
`include "sfe_consts.svh"
module sfe_sync #(
   parameter int         W       = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         rst_n,
   // pins in, synchronised copy out
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   import sfe_pkg::*;
   logic [W-1:0] meta;

   // first stage feeds only the second
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule : sfe_sync

/* logic/sfe_erase_timer.sv */
/*
   Self-timed erase cycle: counts the cycle length of the chosen kind.
   Assumes start is a one-cycle pulse issued only while not busy.
*/
`timescale 1ns/1ps
`include "sfe_consts.svh"
module sfe_erase_timer #(
   parameter int unsigned HALF_CYC = 1,
   parameter int unsigned FULL_CYC = 1,
   parameter int unsigned CHIP_CYC = 1
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // request
   input  wire logic       start,
   input  wire logic [1:0] kind,
   // status
   output logic            busy
);
   import sfe_pkg::*;
   sfe_timer_t st;
   sfe_timer_t next_st;

   // load count on start, run down, drop busy at zero
   always_comb begin
      next_st = st;
      if (start && !st.busy) begin
         next_st.busy = 1'b1;
         case (kind)
            `SFE_KIND_HALF: next_st.count = 32'(HALF_CYC - 1);
            `SFE_KIND_FULL: next_st.count = 32'(FULL_CYC - 1);
            default:        next_st.count = 32'(CHIP_CYC - 1);
         endcase
      end else if (st.busy) begin
         if (st.count == 32'h0000_0000) begin
            next_st.busy = 1'b0;
         end else begin
            next_st.count = st.count - 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign busy = st.busy;

   property p_start_busy;
      @(posedge clock) disable iff (!rst_n)
      (start && !busy) |=> busy [*2];
   endproperty
   a_start_busy: assert property (p_start_busy)
      else $error("busy flag did not follow erase start");
endmodule : sfe_erase_timer

/* logic/sfe_top.sv */
/*
   Command decoder for block erase, chip erase, fast pump mode and the
   three identification reads of a serial flash on its SPI link.
   Assumes the link pins arrive asynchronously to clock, the write unlock
   latch, protection bits and protection lookup live in neighbour logic,
   and a program cycle elsewhere reports itself on ext_busy.
*/
`timescale 1ns/1ps
`include "sfe_consts.svh"
module sfe_top #(
   // identification values, all arbitrary
   parameter logic [7:0]   MAKER_ID  = 8'hA5,
   parameter logic [7:0]   PART_ID   = 8'h5A,
   parameter logic [7:0]   MEM_TYPE  = 8'h3C,
   parameter logic [7:0]   MEM_CAP   = 8'h16,
   parameter logic [127:0] UNIQUE_ID =
      128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210,
   // erase cycle lengths in clock cycles
   parameter int unsigned  HALF_CYC  = `SFE_HALF_BE_US * `SFE_CLK_MHZ,
   parameter int unsigned  FULL_CYC  = `SFE_FULL_BE_US * `SFE_CLK_MHZ,
   parameter int unsigned  CHIP_CYC  = `SFE_CHIP_US * `SFE_CLK_MHZ
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        arst_n,
   // serial link pins
   input  wire logic        cs_n,
   input  wire logic        sclk,
   input  wire logic        si,
   output logic             so,
   output logic             so_oe,
   // write unlock latch and protection settings
   input  wire logic        write_unlock_latch,
   input  wire logic [4:0]  protect_range_bits,
   input  wire logic        protect_invert_bit,
   // protection lookup for the addressed block
   output logic [23:0]      probe_addr,
   output logic             probe_full_block,
   input  wire logic        block_protected,
   // program cycle running elsewhere
   input  wire logic        ext_busy,
   // status and erase requests
   output logic             busy_cycle_flag,
   output logic             fast_pump_flag,
   output logic             write_unlock_clear,
   output logic             erase_start,
   output logic [1:0]       erase_kind,
   output logic [23:0]      erase_base
);
   import sfe_pkg::*;

   logic       rst_q1;
   logic       rst_n;
   logic [2:0] pins_s;
   logic       cs_s;
   logic       sclk_s;
   logic       si_s;
   logic       erase_busy;
   logic       busy_any;
   logic       cs_rise;
   logic       sck_rise;
   logic       sck_fall;
   logic       chip_ok;
   logic       block_op;
   logic       chip_op;
   logic       id_op;
   logic [7:0] new_bits;
   logic [7:0] new_op;
   sfe_state_t st;
   sfe_state_t next_st;

   // reset release through two flip-flops
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_q1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n  <= rst_q1;
      end
   end

   // link pins into the clock domain
   sfe_sync #(
      .W       (3),
      .RST_VAL (`SFE_SYNC_RST)
   ) u_sync (
      .clock (clock),
      .rst_n (rst_n),
      .din   ({cs_n, sclk, si}),
      .dout  (pins_s)
   );

   assign cs_s   = pins_s[2];
   assign sclk_s = pins_s[1];
   assign si_s   = pins_s[0];

   // self-timed erase cycle
   sfe_erase_timer #(
      .HALF_CYC (HALF_CYC),
      .FULL_CYC (FULL_CYC),
      .CHIP_CYC (CHIP_CYC)
   ) u_timer (
      .clock (clock),
      .rst_n (rst_n),
      .start (st.erase_go),
      .kind  (st.erase_kind),
      .busy  (erase_busy)
   );

   // rise of select, and edges of serial clock only inside a frame
   assign cs_rise  = cs_s & ~st.cs_q;
   assign sck_rise = sclk_s & ~st.sclk_q & ~cs_s;
   assign sck_fall = ~sclk_s & st.sclk_q & ~cs_s;
   assign busy_any = erase_busy | ext_busy;

   // chip erase allowed only with range bits 2:0 at 0 and no invert, or at 7 with invert
   assign chip_ok = ((protect_range_bits[2:0] == 3'h0) && !protect_invert_bit)
                 || ((protect_range_bits[2:0] == 3'h7) && protect_invert_bit);

   // opcode classes of the frame just ended
   assign block_op = (st.opcode == `SFE_OP_HALF_BE)
                  || (st.opcode == `SFE_OP_FULL_BE);
   assign chip_op  = (st.opcode == `SFE_OP_CHIP_A)
                  || (st.opcode == `SFE_OP_CHIP_B);

   // bit count and opcode after the current rising edge
   assign new_bits = (st.bits == `SFE_BITS_MAX) ? st.bits
                                                : st.bits + 8'h01;
   assign new_op   = {st.opcode[6:0], si_s};
   assign id_op    = (new_op == `SFE_OP_IDENT)
                  || (new_op == `SFE_OP_MAKER_ID)
                  || (new_op == `SFE_OP_UNIQUE);

   // next state of the decoder
   always_comb begin
      next_st              = st;
      next_st.cs_q         = cs_s;
      next_st.sclk_q       = sclk_s;
      next_st.erase_go     = 1'b0;
      next_st.unlock_clear = 1'b0;

      if (cs_s) begin
         // deselected: drop output and counters
         next_st.phase = SFE_IDLE;
         next_st.bits  = 8'h00;
         next_st.so_oe = 1'b0;
      end else if (st.phase == SFE_IDLE) begin
         next_st.phase  = SFE_RECV;
         next_st.bits   = 8'h00;
         next_st.opcode = 8'h00;
      end

      // input bits on the rising serial clock
      if (sck_rise && (st.phase != SFE_IDLE)) begin
         next_st.bits = new_bits;
         if (st.bits < `SFE_BITS_OP) begin
            next_st.opcode = new_op;
         end else if (st.bits < `SFE_BITS_ADDR) begin
            next_st.addr = {st.addr[22:0], si_s};
         end
         // opcode complete: identification reads gated by busy
         if (new_bits == `SFE_BITS_OP) begin
            next_st.probe_full = (new_op == `SFE_OP_FULL_BE);
            if (id_op && busy_any) begin
               next_st.phase = SFE_SKIP;
            end else if (new_op == `SFE_OP_IDENT) begin
               next_st.phase  = SFE_SEND;
               next_st.out_sr = {MAKER_ID, MEM_TYPE, MEM_CAP, 104'h0};
            end
         end
         // address complete for the maker and part read
         if ((new_bits == `SFE_BITS_ADDR)
             && (st.opcode == `SFE_OP_MAKER_ID)
             && (st.phase == SFE_RECV)) begin
            next_st.phase  = SFE_SEND;
            next_st.out_sr = {MAKER_ID, PART_ID, 112'h0};
         end
         // address and dummy complete for the unique id
         if ((new_bits == `SFE_BITS_UNIQUE)
             && (st.opcode == `SFE_OP_UNIQUE)
             && (st.phase == SFE_RECV)) begin
            next_st.phase  = SFE_SEND;
            next_st.out_sr = UNIQUE_ID;
         end
      end

      // output bits on the falling serial clock, msb first
      if (sck_fall && (st.phase == SFE_SEND)) begin
         next_st.so     = st.out_sr[127];
         next_st.out_sr = {st.out_sr[126:0], 1'b0};
         next_st.so_oe  = 1'b1;
      end

      // end of frame: act on the command just framed
      if (cs_rise && (st.phase == SFE_RECV)) begin
         if (block_op && (st.bits == `SFE_BITS_ADDR)
             && write_unlock_latch
             && !block_protected
             && !busy_any) begin
            next_st.erase_go     = 1'b1;
            next_st.unlock_clear = 1'b1;
            if (st.opcode == `SFE_OP_HALF_BE) begin
               next_st.erase_kind = `SFE_KIND_HALF;
               next_st.erase_base = st.addr & `SFE_HALF_MASK;
            end else begin
               next_st.erase_kind = `SFE_KIND_FULL;
               next_st.erase_base = st.addr & `SFE_FULL_MASK;
            end
         end
         if (chip_op && (st.bits == `SFE_BITS_OP)
             && write_unlock_latch
             && chip_ok
             && !busy_any) begin
            next_st.erase_go     = 1'b1;
            next_st.unlock_clear = 1'b1;
            next_st.erase_kind   = `SFE_KIND_CHIP;
            next_st.erase_base   = 24'h00_0000;
         end
         if ((st.opcode == `SFE_OP_PUMP) && (st.bits == `SFE_BITS_ADDR)) begin
            next_st.fast_pump = 1'b1;
         end
      end

      // release or deep power down leaves fast pump mode
      if (cs_rise && (st.phase != SFE_IDLE) && (st.bits >= `SFE_BITS_OP)
          && ((st.opcode == `SFE_OP_RELEASE)
              || (st.opcode == `SFE_OP_DEEP_PD))) begin
         next_st.fast_pump = 1'b0;
      end
   end

   // decoder register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st      <= '0;
         st.cs_q <= `SFE_CS_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // outputs from registers
   assign so                 = st.so;
   assign so_oe              = st.so_oe;
   assign probe_addr         = st.addr;
   assign probe_full_block   = st.probe_full;
   assign busy_cycle_flag    = erase_busy;
   assign fast_pump_flag     = st.fast_pump;
   assign write_unlock_clear = st.unlock_clear;
   assign erase_start        = st.erase_go;
   assign erase_kind         = st.erase_kind;
   assign erase_base         = st.erase_base;

   // erase start needs the latch set one cycle earlier
   property p_go_unlock;
      @(posedge clock) disable iff (!rst_n)
      st.erase_go |-> $past(write_unlock_latch);
   endproperty
   a_go_unlock: assert property (p_go_unlock)
      else $error("erase started with unlock latch clear");

   // erase start only at the end of a frame
   property p_go_at_rise;
      @(posedge clock) disable iff (!rst_n)
      st.erase_go |-> $past(cs_rise) && cs_s;
   endproperty
   a_go_at_rise: assert property (p_go_at_rise)
      else $error("erase started without select rising");

   // half block base is block aligned
   property p_half_base;
      @(posedge clock) disable iff (!rst_n)
      (st.erase_go && (st.erase_kind == `SFE_KIND_HALF))
         |-> (st.erase_base[14:0] == 15'h0000);
   endproperty
   a_half_base: assert property (p_half_base)
      else $error("half block base not aligned");

   // no block erase into a protected block
   property p_block_prot;
      @(posedge clock) disable iff (!rst_n)
      (st.erase_go && (st.erase_kind != `SFE_KIND_CHIP))
         |-> !$past(block_protected);
   endproperty
   a_block_prot: assert property (p_block_prot)
      else $error("protected block erased");

   // chip erase only with range bits 2:0 at 0 and no invert, or at 7 with invert
   property p_chip_prot;
      @(posedge clock) disable iff (!rst_n)
      (st.erase_go && (st.erase_kind == `SFE_KIND_CHIP)) |-> $past(chip_ok);
   endproperty
   a_chip_prot: assert property (p_chip_prot)
      else $error("chip erase with partial protection");

   // busy flag rises the cycle after an erase start
   property p_go_busy;
      @(posedge clock) disable iff (!rst_n)
      st.erase_go |-> st.unlock_clear ##1 busy_cycle_flag;
   endproperty
   a_go_busy: assert property (p_go_busy)
      else $error("busy flag or latch clear missing after erase start");

   // fast pump flag rises only after the pump command
   property p_pump_set;
      @(posedge clock) disable iff (!rst_n)
      $rose(st.fast_pump) |-> $past(st.opcode == `SFE_OP_PUMP);
   endproperty
   a_pump_set: assert property (p_pump_set)
      else $error("fast pump flag set by another opcode");

   // fast pump flag drops only on release or deep power down
   property p_pump_clr;
      @(posedge clock) disable iff (!rst_n)
      $fell(st.fast_pump) |-> $past((st.opcode == `SFE_OP_RELEASE)
                                 || (st.opcode == `SFE_OP_DEEP_PD));
   endproperty
   a_pump_clr: assert property (p_pump_clr)
      else $error("fast pump flag dropped by another opcode");

   // output released one cycle after select is seen high
   property p_oe_off;
      @(posedge clock) disable iff (!rst_n)
      cs_s |=> !so_oe;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("output still driven after deselect");

   // identification read while busy is skipped
   property p_id_skip;
      @(posedge clock) disable iff (!rst_n)
      (sck_rise && (st.phase == SFE_RECV) && (new_bits == `SFE_BITS_OP)
       && id_op && busy_any) |=> (st.phase == SFE_SKIP);
   endproperty
   a_id_skip: assert property (p_id_skip)
      else $error("identification read decoded while busy");

   // serial output moves only after a falling serial clock
   property p_so_fall;
      @(posedge clock) disable iff (!rst_n)
      $changed(so) |-> $past(sck_fall);
   endproperty
   a_so_fall: assert property (p_so_fall)
      else $error("serial output changed without a falling clock");

   // select high clears the bit count and the frame phase
   property p_frame_clear;
      @(posedge clock) disable iff (!rst_n)
      cs_s |=> (st.bits == 8'h00) && (st.phase == SFE_IDLE);
   endproperty
   a_frame_clear: assert property (p_frame_clear)
      else $error("bit count kept after deselect");
endmodule : sfe_top

/* testbench/sfe_host.sv */
/*
   Host link controller model: frames commands on cs_n, sclk and si and
   collects the bits that come back on so.
   Assumes clock runs at 40 MHz; one sclk period is eight clocks.
*/
`timescale 1ns/1ps
module sfe_host (
   // clock
   input  wire logic clock,
   // link pins towards the device
   output logic      cs_n,
   output logic      sclk,
   output logic      si,
   // link pins from the device
   input  wire logic so,
   input  wire logic so_oe
);
   // idle link: deselected, clock parked low
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si   = 1'b0;
   end

   // one whole frame: ntx bits out msb first, then nrx bits in
   task automatic xfer(input logic [39:0] tx, input int ntx, input int nrx,
                       output logic [127:0] rx, output int oe_cnt);
      int i;
      rx     = '0;
      oe_cnt = 0;
      @(posedge clock);
      cs_n <= 1'b0;
      for (i = 0; i < ntx + nrx; i++) begin
         // si changes only while sclk is low
         if (i < ntx)
            si <= tx[ntx-1-i];
         else
            si <= ~si;
         repeat (5) @(posedge clock);
         // read bit settled since the previous fall
         if (i >= ntx) begin
            rx     = {rx[126:0], so};
            oe_cnt = oe_cnt + int'(so_oe);
         end
         sclk <= 1'b1;
         repeat (3) @(posedge clock);
         sclk <= 1'b0;
      end
      repeat (5) @(posedge clock);
      cs_n <= 1'b1;
      si   <= ~si;
      repeat (6) @(posedge clock);
   endtask : xfer
endmodule : sfe_host

/* testbench/sfe_top_test.sv */
/*
   Self-checking bench for the erase and identification command block.
   Assumes short erase cycle lengths and a neighbour that protects
   every block of the top address byte 3F.
*/
`timescale 1ns/1ps
module sfe_top_test;
   import sfe_pkg::*;
   localparam int HALF = 200, FULL = 300, CHIP = 400;
   localparam logic [127:0] UID = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
   logic        clock, arst_n, cs_n, sclk, si, so, so_oe, got_full;
   logic        write_unlock_latch, protect_invert_bit, block_protected;
   logic        ext_busy, busy_cycle_flag, fast_pump_flag;
   logic        write_unlock_clear, erase_start, probe_full_block;
   logic [4:0]  protect_range_bits;
   logic [23:0] probe_addr, erase_base, got_base;
   logic [1:0]  erase_kind, got_kind;
   logic [127:0] rx;
   int          num_errors, compares, n_start, wuc_bad, run, busy_len, oe;

   // clock and neighbour protection lookup
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   assign block_protected = (probe_addr[23:16] == 8'h3F);

   sfe_top #(.HALF_CYC(HALF), .FULL_CYC(FULL), .CHIP_CYC(CHIP)) i_sfe_top (
      .clock(clock), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk), .si(si),
      .so(so), .so_oe(so_oe), .write_unlock_latch(write_unlock_latch),
      .protect_range_bits(protect_range_bits),
      .protect_invert_bit(protect_invert_bit), .probe_addr(probe_addr),
      .probe_full_block(probe_full_block),
      .block_protected(block_protected), .ext_busy(ext_busy),
      .busy_cycle_flag(busy_cycle_flag), .fast_pump_flag(fast_pump_flag),
      .write_unlock_clear(write_unlock_clear), .erase_start(erase_start),
      .erase_kind(erase_kind), .erase_base(erase_base));

   sfe_host i_sfe_host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .si(si),
                        .so(so), .so_oe(so_oe));

   // erase pulse capture and busy run length
   always @(posedge clock) begin
      if (erase_start === 1'b1) begin
         n_start  = n_start + 1;
         got_kind = erase_kind;
         got_base = erase_base;
         got_full = probe_full_block;
      end
      if (write_unlock_clear !== erase_start) wuc_bad = wuc_bad + 1;
      if (busy_cycle_flag === 1'b1) run = run + 1;
      else if (run != 0) begin
         busy_len = run;
         run      = 0;
      end
   end

   task automatic chk(input string what, input logic [127:0] exp,
                      input logic [127:0] got);
      compares = compares + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one erase frame, then the pulse, kind, base and busy length
   task automatic do_erase(input logic [39:0] tx, input int nb,
                           input int n_exp, input logic [1:0] kind,
                           input logic [23:0] base, input int cyc);
      int s;
      int k;
      s        = n_start;
      busy_len = 0;
      i_sfe_host.xfer(tx, nb, 0, rx, oe);
      k = 0;
      while (busy_cycle_flag === 1'b1 && k < 1000) begin
         @(posedge clock);
         k++;
      end
      repeat (2) @(posedge clock);
      chk("erase starts", n_exp, n_start - s);
      chk("busy length", cyc, busy_len);
      chk("unlock clear beside start", 0, wuc_bad);
      if (n_exp == 1) begin
         chk("erase kind", kind, got_kind);
         chk("erase base", base, got_base);
         chk("probe full block", kind == 2'h1, got_full);
      end
   endtask : do_erase

   task automatic t_block_erase;
      write_unlock_latch <= 1'b1;
      do_erase(40'h52_12AB_CD, 32, 1, 2'h0, 24'h12_8000, HALF);
      do_erase(40'h52_1234_56, 32, 1, 2'h0, 24'h12_0000, HALF);
      do_erase(40'hD8_3456_78, 32, 1, 2'h1, 24'h34_0000, FULL);
      do_erase({7'h0, 8'h52, 24'h12_ABCD, 1'b0}, 33, 0, 0, 0, 0);
      do_erase(40'h52_12AB, 24, 0, 0, 0, 0);
      do_erase(40'h52_3F80_00, 32, 0, 0, 0, 0);
      do_erase(40'hD8_3F12_34, 32, 0, 0, 0, 0);
      write_unlock_latch <= 1'b0;
      do_erase(40'hD8_1111_11, 32, 0, 0, 0, 0);
      do_erase(40'h52_1111_11, 32, 0, 0, 0, 0);
   endtask : t_block_erase

   task automatic t_chip_erase;
      write_unlock_latch <= 1'b1;
      protect_range_bits <= 5'h00;
      protect_invert_bit <= 1'b0;
      do_erase(40'h60, 8, 1, 2'h2, 24'h00_0000, CHIP);
      do_erase(40'h6000, 16, 0, 0, 0, 0);
      protect_range_bits <= 5'h07;
      protect_invert_bit <= 1'b1;
      do_erase(40'hC7, 8, 1, 2'h2, 24'h00_0000, CHIP);
      protect_range_bits <= 5'h01;
      protect_invert_bit <= 1'b0;
      do_erase(40'h60, 8, 0, 0, 0, 0);
      protect_range_bits <= 5'h00;
      protect_invert_bit <= 1'b1;
      do_erase(40'hC7, 8, 0, 0, 0, 0);
      protect_invert_bit <= 1'b0;
   endtask : t_chip_erase

   task automatic t_fast_pump;
      i_sfe_host.xfer(40'hA3_0000_00, 32, 0, rx, oe);
      chk("pump flag set", 1'b1, fast_pump_flag);
      i_sfe_host.xfer(40'hAB, 8, 0, rx, oe);
      chk("pump flag released", 1'b0, fast_pump_flag);
      i_sfe_host.xfer(40'hA3_0000_00, 32, 0, rx, oe);
      chk("pump flag set again", 1'b1, fast_pump_flag);
      i_sfe_host.xfer(40'hB9, 8, 0, rx, oe);
      chk("pump flag power down", 1'b0, fast_pump_flag);
      i_sfe_host.xfer(40'hAB, 8, 0, rx, oe);
   endtask : t_fast_pump

   task automatic t_ident;
      i_sfe_host.xfer(40'h9F, 8, 24, rx, oe);
      chk("ident bytes", {8'hA5, 8'h3C, 8'h16}, rx[23:0]);
      chk("ident driven", 24, oe);
      chk("output released", 1'b0, so_oe);
      i_sfe_host.xfer(40'h90_0000_00, 32, 16, rx, oe);
      chk("maker part", {8'hA5, 8'h5A}, rx[15:0]);
      i_sfe_host.xfer(40'h4B_0000_0000, 40, 128, rx, oe);
      chk("unique id", UID, rx);
      i_sfe_host.xfer(40'h9F, 8, 4, rx, oe);
      chk("ident cut short", 4'hA, rx[3:0]);
      chk("output dropped", 1'b0, so_oe);
      i_sfe_host.xfer(40'h9F, 8, 8, rx, oe);
      chk("fresh opcode", 8'hA5, rx[7:0]);
   endtask : t_ident

   task automatic t_ident_busy;
      write_unlock_latch <= 1'b1;
      busy_len = 0;
      i_sfe_host.xfer(40'h52_0000_00, 32, 0, rx, oe);
      i_sfe_host.xfer(40'h9F, 8, 8, rx, oe);
      chk("ident while erasing", 0, oe);
      repeat (HALF) @(posedge clock);
      chk("erase undisturbed", HALF, busy_len);
      ext_busy <= 1'b1;
      i_sfe_host.xfer(40'h4B_0000_0000, 40, 8, rx, oe);
      chk("unique while programming", 0, oe);
      ext_busy <= 1'b0;
   endtask : t_ident_busy

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   // watchdog
   initial begin
      repeat (60000) @(posedge clock);
      num_errors = num_errors + 1;
      $display("CHECK FAILED watchdog expected done seen hang");
      tally_and_finish();
   end

   // main sequence
   initial begin
      num_errors = 0;
      compares = 0;
      n_start = 0;
      wuc_bad = 0;
      run = 0;
      busy_len = 0;
      arst_n = 1'b0;
      write_unlock_latch = 1'b0;
      protect_range_bits = 5'h00;
      protect_invert_bit = 1'b0;
      ext_busy = 1'b0;
      repeat (20) @(posedge clock);
      arst_n <= 1'b1;
      repeat (8) @(posedge clock);
      t_block_erase();
      t_chip_erase();
      t_fast_pump();
      t_ident();
      t_ident_busy();
      tally_and_finish();
   end
endmodule : sfe_top_test
